// [misc_config_defs.vh]
// Constants for the miscellaneous configuration register block:
// offset, field positions, masks, reset value and small timing counts.
// Assumes byte addresses within the 256-byte configuration space.
`ifndef MISC_CONFIG_DEFS_VH
`define MISC_CONFIG_DEFS_VH

// ****************************************
// Register map
// ****************************************
`define MISC_CONFIG_OFFSET      8'hf0
`define MISC_CONFIG_RESET       32'h0000_0000
`define MISC_CONFIG_WRITE_MASK  32'h0000_801f

// ****************************************
// Field positions
// ****************************************
`define COLD_WAKE_BIT           15
`define ABORT_SUPPRESS_BIT      4
`define TWOWIRE_ROUTE_BIT       3
`define LINK_GATE_OFF_BIT       2
`define HOST_GATE_OFF_BIT       1
`define KEEP_HOST_CLOCK_BIT     0

// ****************************************
// Data and timing
// ****************************************
`define STOPPED_LINK_DATA       32'hffff_ffff
`define CLOCK_RUN_DRIVE_CYCLES  4'h2

`endif

// [gpio_pin_route.v]
// One general-purpose pin with its optional two-wire routing.
// Assumes pin input is synchronous to clk; the pad resolves the wire.
`timescale 1ns/1ps
`include "misc_config_defs.vh"

module gpio_pin_route (
	input  wire clk,
	input  wire rst_b,
	input  wire route,
	input  wire gpio_out,
	input  wire gpio_oe,
	input  wire pin_in,
	output reg  pin_out,
	output reg  pin_oe,
	output reg  gpio_in,
	output reg  twowire_in
);

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pin_out    <= 1'b0;
			pin_oe     <= 1'b0;
			gpio_in    <= 1'b0;
			twowire_in <= 1'b1;
		end else begin
			// Routed pin is never driven by the general-purpose logic
			pin_out    <= route ? 1'b0 : gpio_out;
			pin_oe     <= route ? 1'b0 : gpio_oe;
			gpio_in    <= pin_in;
			// Idle two-wire line reads high when not routed
			twowire_in <= route ? pin_in : 1'b1;
		end
	end

endmodule // gpio_pin_route

// [clock_run_keeper.v]
// Clock-run agent: pulls the open-drain clock-run line low to keep
// the host-bus clock running. Assumes the line input is synchronous.
`timescale 1ns/1ps
`include "misc_config_defs.vh"

module clock_run_keeper (
	input  wire clk,
	input  wire rst_b,
	input  wire keep_running,
	input  wire activity_pending,
	input  wire line_in,
	output reg  line_out,
	output reg  line_oe,
	output reg  stop_allowed
);

	localparam [2:0] ST_IDLE  = 3'b001;
	localparam [2:0] ST_DRIVE = 3'b010;
	localparam [2:0] ST_SETTLE = 3'b100;

	reg [2:0] state;
	reg [3:0] count;
	wire      want_clock;

	assign want_clock = keep_running | activity_pending;

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state        <= ST_IDLE;
			count        <= 4'h0;
			line_out     <= 1'b0;
			line_oe      <= 1'b0;
			stop_allowed <= 1'b1;
		end else begin
			line_out     <= 1'b0;
			stop_allowed <= ~want_clock;
			case (state)
				ST_IDLE: begin
					// Host deasserts the line (high) when it wants to stop
					if (line_in && want_clock) begin
						state   <= ST_DRIVE;
						count   <= `CLOCK_RUN_DRIVE_CYCLES;
						line_oe <= 1'b1;
					end
				end
				ST_DRIVE: begin
					if (count == 4'h1) begin
						state   <= ST_SETTLE;
						line_oe <= 1'b0;
					end
					count <= count - 4'h1;
				end
				ST_SETTLE: begin
					// One cycle for the pull-up before sampling again
					state <= ST_IDLE;
				end
				default: begin
					state   <= ST_IDLE;
					line_oe <= 1'b0;
				end
			endcase
		end
	end

endmodule // clock_run_keeper

// [misc_config_register.v]
// Miscellaneous configuration register of the host-bus side of a
// serial-bus link controller, with the logic its bits steer.
// Assumes configuration accesses come as one-cycle strobes on clk and
// that the link side answers forwarded accesses with a one-cycle ack.
// The clock-run line needs an external pull-up; the pads resolve the pins.
`timescale 1ns/1ps
`include "misc_config_defs.vh"

module misc_config_register (
	input  wire        clk,
	input  wire        rst_b,
	// Configuration space access
	input  wire        cfg_sel,
	input  wire        cfg_write,
	input  wire [7:0]  cfg_offset,
	input  wire [3:0]  cfg_byte_en,
	input  wire [31:0] cfg_wdata,
	output reg         cfg_ack,
	output reg         cfg_hit,
	output reg  [31:0] cfg_rdata,
	// Host access to link-domain registers
	input  wire        link_req,
	input  wire        link_write,
	input  wire        link_clock_active,
	input  wire        link_ack_in,
	input  wire [31:0] link_rdata_in,
	output reg         link_fwd,
	output reg         link_done,
	output reg         link_target_abort,
	output reg  [31:0] link_rdata,
	// Power management capability mirror
	output reg         cap_cold_state_wake_support,
	// Clock gating
	input  wire        link_clock_wanted,
	input  wire        host_clock_wanted,
	output reg         link_clock_enable,
	output reg         host_clock_enable,
	// Clock-run line, open drain
	input  wire        activity_pending,
	input  wire        clock_run_pin_in,
	output wire        clock_run_pin_out,
	output wire        clock_run_pin_oe,
	output wire        host_clock_stop_allowed,
	// General-purpose pins
	input  wire        gpio_three_out,
	input  wire        gpio_three_oe,
	input  wire        gpio_two_out,
	input  wire        gpio_two_oe,
	input  wire        general_pin_three_in,
	input  wire        general_pin_two_in,
	output wire        general_pin_three_out,
	output wire        general_pin_three_oe,
	output wire        general_pin_two_out,
	output wire        general_pin_two_oe,
	output wire        gpio_three_in,
	output wire        gpio_two_in,
	output wire        twowire_scl_in,
	output wire        twowire_sda_in
);

	// ****************************************
	// Register storage
	// ****************************************
	reg         cold_state_wake_support;
	reg         abort_suppress;
	reg         gpio_to_twowire_route;
	reg         link_clock_gate_off;
	reg         host_clock_gate_off;
	reg         keep_host_clock;

	wire        reg_hit;
	wire [31:0] write_mask;
	wire [31:0] current;
	wire [31:0] next_value;
	reg         next_cold_state_wake_support;
	reg         next_abort_suppress;
	reg         next_gpio_to_twowire_route;
	reg         next_link_clock_gate_off;
	reg         next_host_clock_gate_off;
	reg         next_keep_host_clock;
	wire        reg_write;

	localparam [31:0] RESET_VALUE = `MISC_CONFIG_RESET;

	// ****************************************
	// Write decode
	// ****************************************
	assign reg_hit   = (cfg_offset == `MISC_CONFIG_OFFSET);
	assign reg_write = cfg_sel & cfg_write & reg_hit;

	// Byte enables narrow the writable mask lane by lane
	assign write_mask = `MISC_CONFIG_WRITE_MASK &
		{{8{cfg_byte_en[3]}}, {8{cfg_byte_en[2]}},
		 {8{cfg_byte_en[1]}}, {8{cfg_byte_en[0]}}};

	// Reserved fields are constant zero, so reads and writes cannot touch them
	assign current = {16'h0000,
		cold_state_wake_support,
		10'h000,
		abort_suppress,
		gpio_to_twowire_route,
		link_clock_gate_off,
		host_clock_gate_off,
		keep_host_clock};

	assign next_value = (current & ~write_mask) | (cfg_wdata & write_mask);

	// ****************************************
	// Next field values
	// ****************************************
	// Only an accepted write to this offset moves a field; keeping the
	// decode here leaves the clocked block a plain load on every edge
	always @* begin
		next_cold_state_wake_support = cold_state_wake_support;
		next_abort_suppress          = abort_suppress;
		next_gpio_to_twowire_route   = gpio_to_twowire_route;
		next_link_clock_gate_off     = link_clock_gate_off;
		next_host_clock_gate_off     = host_clock_gate_off;
		next_keep_host_clock         = keep_host_clock;
		if (reg_write) begin
			next_cold_state_wake_support = next_value[`COLD_WAKE_BIT];
			next_abort_suppress          = next_value[`ABORT_SUPPRESS_BIT];
			next_gpio_to_twowire_route   = next_value[`TWOWIRE_ROUTE_BIT];
			next_link_clock_gate_off     = next_value[`LINK_GATE_OFF_BIT];
			next_host_clock_gate_off     = next_value[`HOST_GATE_OFF_BIT];
			next_keep_host_clock         = next_value[`KEEP_HOST_CLOCK_BIT];
		end
	end

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cold_state_wake_support <= RESET_VALUE[`COLD_WAKE_BIT];
			abort_suppress          <= RESET_VALUE[`ABORT_SUPPRESS_BIT];
			gpio_to_twowire_route   <= RESET_VALUE[`TWOWIRE_ROUTE_BIT];
			link_clock_gate_off     <= RESET_VALUE[`LINK_GATE_OFF_BIT];
			host_clock_gate_off     <= RESET_VALUE[`HOST_GATE_OFF_BIT];
			keep_host_clock         <= RESET_VALUE[`KEEP_HOST_CLOCK_BIT];
		end else begin
			cold_state_wake_support <= next_cold_state_wake_support;
			abort_suppress          <= next_abort_suppress;
			gpio_to_twowire_route   <= next_gpio_to_twowire_route;
			link_clock_gate_off     <= next_link_clock_gate_off;
			host_clock_gate_off     <= next_host_clock_gate_off;
			keep_host_clock         <= next_keep_host_clock;
		end
	end

	// ****************************************
	// Configuration answer
	// ****************************************
	// Reads show the value before any write in the same strobe, so a
	// write is seen by the next read access, never by its own answer
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cfg_ack   <= 1'b0;
			cfg_hit   <= 1'b0;
			cfg_rdata <= 32'h0000_0000;
		end else begin
			cfg_ack <= cfg_sel;
			cfg_hit <= cfg_sel & reg_hit;
			if (cfg_sel && !cfg_write && reg_hit) begin
				cfg_rdata <= current;
			end else if (cfg_sel) begin
				// Unmapped offsets and writes return zero
				cfg_rdata <= 32'h0000_0000;
			end
		end
	end

	// ****************************************
	// Mirrors and clock gating
	// ****************************************
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cap_cold_state_wake_support <= 1'b0;
			link_clock_enable           <= 1'b0;
			host_clock_enable           <= 1'b0;
		end else begin
			cap_cold_state_wake_support <= cold_state_wake_support;
			// Registered so a gate enable never glitches on the decode
			// Test overrides bypass gating; normal use leaves them clear
			link_clock_enable <= link_clock_gate_off | link_clock_wanted;
			host_clock_enable <= host_clock_gate_off | host_clock_wanted;
		end
	end

	// ****************************************
	// Link register access
	// ****************************************
	localparam [2:0] LS_IDLE = 3'b001;
	localparam [2:0] LS_WAIT = 3'b010;
	localparam [2:0] LS_DONE = 3'b100;

	reg [2:0] link_state;

	// A request while busy or in the gap cycle is dropped, not queued;
	// the host side must retry it.

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			link_state        <= LS_IDLE;
			link_fwd          <= 1'b0;
			link_done         <= 1'b0;
			link_target_abort <= 1'b0;
			link_rdata        <= 32'h0000_0000;
		end else begin
			link_fwd          <= 1'b0;
			link_done         <= 1'b0;
			link_target_abort <= 1'b0;
			case (link_state)
				LS_IDLE: begin
					if (link_req && link_clock_active) begin
						link_fwd   <= 1'b1;
						link_state <= LS_WAIT;
					end else if (link_req && abort_suppress) begin
						// Writes to a stopped domain are dropped
						link_rdata <= `STOPPED_LINK_DATA;
						link_done  <= 1'b1;
						link_state <= LS_DONE;
					end else if (link_req) begin
						// Some systems treat this abort as fatal
						link_target_abort <= 1'b1;
						link_state        <= LS_DONE;
					end
				end
				LS_WAIT: begin
					if (link_ack_in) begin
						link_rdata <= link_write ? 32'h0000_0000 : link_rdata_in;
						link_done  <= 1'b1;
						link_state <= LS_DONE;
					end else if (!link_clock_active && abort_suppress) begin
						// Clock stopped mid-access: no ack will come
						link_rdata <= `STOPPED_LINK_DATA;
						link_done  <= 1'b1;
						link_state <= LS_DONE;
					end else if (!link_clock_active) begin
						link_target_abort <= 1'b1;
						link_state        <= LS_DONE;
					end
				end
				LS_DONE: begin
					// One idle cycle between accesses
					link_state <= LS_IDLE;
				end
				default: begin
					link_state <= LS_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// Clock-run and pins
	// ****************************************
	clock_run_keeper u_clock_run (
		.clk              (clk),
		.rst_b            (rst_b),
		.keep_running     (keep_host_clock),
		.activity_pending (activity_pending),
		.line_in          (clock_run_pin_in),
		.line_out         (clock_run_pin_out),
		.line_oe          (clock_run_pin_oe),
		.stop_allowed     (host_clock_stop_allowed)
	);

	// One routing bit moves both pins together; the two-wire port's own
	// drive sits outside this block and only sees the pin levels here.
	gpio_pin_route u_pin_three (
		.clk        (clk),
		.rst_b      (rst_b),
		.route      (gpio_to_twowire_route),
		.gpio_out   (gpio_three_out),
		.gpio_oe    (gpio_three_oe),
		.pin_in     (general_pin_three_in),
		.pin_out    (general_pin_three_out),
		.pin_oe     (general_pin_three_oe),
		.gpio_in    (gpio_three_in),
		.twowire_in (twowire_scl_in)
	);

	gpio_pin_route u_pin_two (
		.clk        (clk),
		.rst_b      (rst_b),
		.route      (gpio_to_twowire_route),
		.gpio_out   (gpio_two_out),
		.gpio_oe    (gpio_two_oe),
		.pin_in     (general_pin_two_in),
		.pin_out    (general_pin_two_out),
		.pin_oe     (general_pin_two_oe),
		.gpio_in    (gpio_two_in),
		.twowire_in (twowire_sda_in)
	);

endmodule // misc_config_register

// [misc_config_chk.sv]
// Port checker for the miscellaneous configuration register.
// Assumes it is bound to misc_config_register; one clock domain.
`timescale 1ns/1ps
module misc_config_chk (
	input wire logic        clk,
	input wire logic        rst_b,
	input wire logic        cfg_sel,
	input wire logic        cfg_write,
	input wire logic        cfg_ack,
	input wire logic [7:0]  cfg_offset,
	input wire logic [3:0]  cfg_byte_en,
	input wire logic [31:0] cfg_wdata,
	input wire logic [31:0] cfg_rdata,
	input wire logic [31:0] link_rdata,
	input wire logic        link_req,
	input wire logic        link_clock_active,
	input wire logic        link_done,
	input wire logic        link_target_abort,
	input wire logic        link_fwd,
	input wire logic        cap_cold_state_wake_support,
	input wire logic        link_clock_enable,
	input wire logic        host_clock_enable,
	input wire logic        activity_pending,
	input wire logic        clock_run_pin_in,
	input wire logic        clock_run_pin_oe,
	input wire logic        host_clock_stop_allowed,
	input wire logic        general_pin_three_in,
	input wire logic        general_pin_two_in,
	input wire logic        general_pin_three_oe,
	input wire logic        general_pin_two_oe,
	input wire logic        twowire_scl_in,
	input wire logic        twowire_sda_in
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// Shadow of the low control bits, written on the accepting edge
	logic [4:0] low;
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			low <= 5'h00;
		else if (cfg_sel && cfg_write && cfg_offset == 8'hf0 && cfg_byte_en[0])
			low <= cfg_wdata[4:0];
	end
	wire idle = !link_fwd && !link_done && !link_target_abort;
	sequence s_drive;
		clock_run_pin_oe [*2] ##1 !clock_run_pin_oe;
	endsequence
	property p_zero; cfg_ack |-> cfg_rdata[31:16] == 16'h0000 && cfg_rdata[14:5] == 10'h000;
	endproperty
	a_zero: assert property (p_zero) else $error("read-zero bits set");
	property p_mirror; cfg_ack && !$past(cfg_write) && $past(cfg_offset) == 8'hf0
		|-> cfg_rdata[15] == cap_cold_state_wake_support; endproperty
	a_mirror: assert property (p_mirror) else $error("mirror differs");
	property p_abort; link_req && !link_clock_active && !low[4] && idle
		|=> link_target_abort && !link_done; endproperty
	a_abort: assert property (p_abort) else $error("no abort");
	property p_ffdata; link_req && !link_clock_active && low[4] && idle
		|=> link_done && !link_target_abort && link_rdata == 32'hffff_ffff; endproperty
	a_ffdata: assert property (p_ffdata) else $error("no ones data");
	property p_route_in; low[3] |=> twowire_scl_in == $past(general_pin_three_in)
		&& twowire_sda_in == $past(general_pin_two_in); endproperty
	a_route_in: assert property (p_route_in) else $error("pin not routed");
	property p_route_oe; low[3] |=> !general_pin_three_oe && !general_pin_two_oe; endproperty
	a_route_oe: assert property (p_route_oe) else $error("routed pin driven");
	property p_lgate; low[2] |=> link_clock_enable; endproperty
	a_lgate: assert property (p_lgate) else $error("link clock gated");
	property p_hgate; low[1] |=> host_clock_enable; endproperty
	a_hgate: assert property (p_hgate) else $error("host clock gated");
	property p_keep; low[0] && clock_run_pin_in && !clock_run_pin_oe
		&& !$past(clock_run_pin_oe) |=> s_drive; endproperty
	a_keep: assert property (p_keep) else $error("clock run not driven");
	property p_hold; low[0] [*2] |-> !host_clock_stop_allowed; endproperty
	a_hold: assert property (p_hold) else $error("stop allowed");
	property p_let; (!low[0] && !activity_pending) [*2] |-> host_clock_stop_allowed; endproperty
	a_let: assert property (p_let) else $error("stop refused");
endmodule // misc_config_chk

bind misc_config_register misc_config_chk misc_config_chk_inst (.*);

// [link_side_model.sv]
// Link-domain responder: acks a forwarded access after a set delay.
// Assumes link_fwd is a one-cycle pulse on clk.
`timescale 1ns/1ps
module link_side_model (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        link_fwd,
	input  wire logic [3:0]  delay,
	input  wire logic [31:0] word,
	output logic             link_ack_in,
	output logic [31:0]      link_rdata_in
);
	logic [4:0] cnt;
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt <= 5'h00;
			link_ack_in <= 1'b0;
			link_rdata_in <= 32'h0000_0000;
		end else begin
			link_ack_in <= 1'b0;
			// Data is valid only with the ack; show its inverse otherwise
			link_rdata_in <= ~word;
			if (link_fwd)
				cnt <= {1'b0, delay} + 5'h01;
			else if (cnt == 5'h01) begin
				cnt <= 5'h00;
				link_ack_in <= 1'b1;
				link_rdata_in <= word;
			end else if (cnt != 5'h00)
				cnt <= cnt - 5'h01;
		end
	end
endmodule // link_side_model

// [misc_config_register_bench.sv]
// Self-checking bench for the miscellaneous configuration register.
// Assumes config answers come one cycle after the strobe.
`timescale 1ns/1ps
module misc_config_register_bench;
	logic        clk = 1'b0, rst_b = 1'b0, cfg_sel = 1'b0, cfg_write = 1'b0, link_req = 1'b0;
	logic        link_write = 1'b0, link_clock_active = 1'b0, activity_pending = 1'b0, ab, fw;
	logic        link_clock_wanted = 1'b0, host_clock_wanted = 1'b0, ext3 = 1'b1, ext2 = 1'b1;
	logic        gpio_three_out = 1'b0, gpio_three_oe = 1'b0, gpio_two_out = 1'b0;
	logic        gpio_two_oe = 1'b0, hit;
	logic [7:0]  cfg_offset = 8'h00;
	logic [3:0]  cfg_byte_en = 4'h0, delay = 4'h0;
	logic [31:0] cfg_wdata = 32'h0000_0000, word = 32'h5a5a_c3c3, rd;
	int          error_cnt = 0, cmp_count = 0;
	wire         cfg_ack, cfg_hit, link_fwd, link_done, link_target_abort, link_ack_in;
	wire         cap_cold_state_wake_support, link_clock_enable, host_clock_enable;
	wire         clock_run_pin_out, clock_run_pin_oe, host_clock_stop_allowed;
	wire         general_pin_three_out, general_pin_three_oe, general_pin_two_out;
	wire         general_pin_two_oe, gpio_three_in, gpio_two_in, twowire_scl_in, twowire_sda_in;
	wire  [31:0] cfg_rdata, link_rdata, link_rdata_in;
	// Clock-run line is pulled up; undriven pins show the far side's level
	wire clock_run_pin_in = !clock_run_pin_oe;
	wire general_pin_three_in = general_pin_three_oe ? general_pin_three_out : ext3;
	wire general_pin_two_in = general_pin_two_oe ? general_pin_two_out : ext2;
	misc_config_register misc_config_register_inst (.*);
	link_side_model link_side_model_inst (.*);
	always #25 clk = ~clk;
	task automatic chk(input string what, input logic [31:0] exp, got);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cfg(input logic w, input logic [7:0] off, input logic [3:0] be,
		input logic [31:0] d);
		@(posedge clk);
		cfg_sel <= 1'b1;
		cfg_write <= w;
		cfg_offset <= off;
		cfg_byte_en <= be;
		cfg_wdata <= d;
		@(posedge clk);
		cfg_sel <= 1'b0;
		#1;
		chk("ack", 32'h0000_0001, {31'h0, cfg_ack});
		rd = cfg_rdata;
		hit = cfg_hit;
	endtask
	task automatic link(input logic act, input logic [3:0] dl);
		int i;
		@(posedge clk);
		link_req <= 1'b1;
		link_clock_active <= act;
		delay <= dl;
		@(posedge clk);
		link_req <= 1'b0;
		#1;
		fw = link_fwd;
		for (i = 0; i < 30 && link_done !== 1'b1 && link_target_abort !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		ab = link_target_abort;
		rd = link_rdata;
		repeat (2) @(posedge clk);
	endtask
	task automatic t_fields;
		cfg(1'b0, 8'hf0, 4'hf, 32'h0000_0000);
		chk("reset value", 32'h0000_0000, rd);
		cfg(1'b1, 8'hf0, 4'hf, 32'hffff_fffe);
		cfg(1'b0, 8'hf0, 4'hf, 32'h0000_0000);
		chk("bits", 32'h0000_801e, rd);
		chk("hit", 32'h0000_0001, {31'h0, hit});
		chk("mirror", 32'h0000_0001, {31'h0, cap_cold_state_wake_support});
		chk("gates", 32'h0000_0003, {30'h0, link_clock_enable, host_clock_enable});
		cfg(1'b1, 8'hf0, 4'he, 32'h0000_0000);
		cfg(1'b0, 8'hf0, 4'hf, 32'h0000_0000);
		chk("lanes", 32'h0000_001e, rd);
		chk("mirror off", 32'h0000_0000, {31'h0, cap_cold_state_wake_support});
		cfg(1'b0, 8'hf4, 4'hf, 32'h0000_0000);
		chk("unmapped", 32'h0000_0000, {31'h0, hit});
	endtask
	task automatic t_pins;
		@(posedge clk);
		{gpio_three_out, gpio_three_oe, gpio_two_out, gpio_two_oe} <= 4'h5;
		ext3 <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		chk("routed oe", 32'h0000_0000, {30'h0, general_pin_three_oe, general_pin_two_oe});
		chk("routed", 32'h0000_0001, {30'h0, twowire_scl_in, twowire_sda_in});
		chk("levels routed", 32'h0000_0001, {30'h0, gpio_three_in, gpio_two_in});
		cfg(1'b1, 8'hf0, 4'hf, 32'h0000_0010);
		repeat (3) @(posedge clk);
		#1;
		chk("pins", 32'h0000_0005, {28'h0, general_pin_three_out, general_pin_three_oe,
			general_pin_two_out, general_pin_two_oe});
		chk("unrouted", 32'h0000_0003, {30'h0, twowire_scl_in, twowire_sda_in});
		chk("levels", 32'h0000_0000, {30'h0, gpio_three_in, gpio_two_in});
		chk("gates off", 32'h0000_0000, {30'h0, link_clock_enable, host_clock_enable});
	endtask
	task automatic t_link;
		link(1'b0, 4'h0);
		chk("ones data", 32'hffff_ffff, rd);
		chk("no abort", 32'h0000_0000, {31'h0, ab});
		chk("no forward", 32'h0000_0000, {31'h0, fw});
		link(1'b1, 4'h6);
		chk("forwarded", word, rd);
		chk("forward", 32'h0000_0001, {31'h0, fw});
		link_write <= 1'b1;
		link(1'b1, 4'h2);
		chk("write data", 32'h0000_0000, rd);
		link_write <= 1'b0;
		cfg(1'b1, 8'hf0, 4'hf, 32'h0000_0000);
		link(1'b0, 4'h0);
		chk("abort", 32'h0000_0001, {31'h0, ab});
	endtask
	task automatic t_clkrun;
		int n;
		n = 0;
		cfg(1'b1, 8'hf0, 4'hf, 32'h0000_0001);
		repeat (2) @(posedge clk);
		#1;
		chk("stop held", 32'h0000_0000, {31'h0, host_clock_stop_allowed});
		repeat (8) begin
			@(posedge clk);
			#1;
			n += clock_run_pin_oe;
		end
		chk("drive cycles", 32'h0000_0004, n);
		chk("pin out", 32'h0000_0000, {31'h0, clock_run_pin_out});
		cfg(1'b1, 8'hf0, 4'hf, 32'h0000_0000);
		@(posedge clk);
		activity_pending <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		chk("busy", 32'h0000_0000, {31'h0, host_clock_stop_allowed});
		@(posedge clk);
		activity_pending <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		chk("idle", 32'h0000_0001, {31'h0, host_clock_stop_allowed});
	endtask
	task automatic wrap_up;
		if (error_cnt == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		t_fields;
		t_pins;
		t_link;
		t_clkrun;
		wrap_up;
	end
	initial begin
		#2000000;
		error_cnt++;
		wrap_up;
	end
endmodule // misc_config_register_bench
